// *** logic/wief_pkg.sv ***
/*
 * Package for the wake and interrupt enable flag block: flag positions,
 * reset values, body variant encoding.
 * Assumes one core clock and an instruction decoder outside the block.
 */
package wief_pkg;
    localparam int FLAG_W = 8;
    localparam int SRC_N = 5;
    // flag bit positions in both sets
    localparam int BIT_DIV0 = 0;
    localparam int BIT_TMR0 = 1;
    localparam int BIT_PORT = 2;
    localparam int BIT_SRC4 = 4;
    localparam int BIT_TMR1 = 7;
    // implemented bits; 3, 5 and 6 are reserved
    localparam logic [FLAG_W-1:0] FLAG_MASK = 8'h97;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] FLAG_ZERO = 8'h00;
    // event source index order on the event vector
    localparam int EV_DIV0 = 0;
    localparam int EV_TMR0 = 1;
    localparam int EV_PORT = 2;
    localparam int EV_SRC4 = 3;
    localparam int EV_TMR1 = 4;

    typedef enum logic [0:0] {
        WIEF_BODY_DIV1 = 1'b0,
        WIEF_BODY_EXTPIN = 1'b1
    } wief_body_t;
endpackage

// *** logic/wief_if.sv ***
/*
 * Interface carrying qualified event pulses from the source selector
 * to the flag block. Assumes a single clock shared by both ends.
 */
interface wief_ev_if;
    import wief_pkg::*;
    logic [SRC_N-1:0] ev;
    modport src (output ev);
    modport dst (input ev);
endinterface

// *** logic/wief_src_sel.sv ***
/*
 * Event source selector: synchronises the external interrupt pin and the
 * change sense port, detects the falling edge and any change, and picks
 * the body dependent source 4. Assumes internal events are one-cycle
 * pulses on ref_clk.
 */
module wief_src_sel
    import wief_pkg::*;
#(
    parameter int PORT_W = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // body strap and raw events
    input wire wief_pkg::wief_body_t body_sel,
    input wire logic div0_ovf,
    input wire logic tmr0_udf,
    input wire logic div1_ovf,
    input wire logic tmr1_udf,
    input wire logic ext_int_pin,
    input wire logic [PORT_W-1:0] change_sense_port,
    // qualified events
    wief_ev_if.src evo
);
    // pipeline depth from the pin to the last synchroniser stage
    localparam int SETTLE_N = 3;

    typedef struct packed {
        logic [SETTLE_N-1:0] warm;
        logic int_s1;
        logic int_s2;
        logic int_s3;
        logic [PORT_W-1:0] port_s1;
        logic [PORT_W-1:0] port_s2;
        logic [PORT_W-1:0] port_s3;
    } wief_sel_st_t;

    wief_sel_st_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.warm = {st_ff.warm[SETTLE_N-2:0], 1'b1};
        nxt_st.int_s1 = ext_int_pin;
        nxt_st.int_s2 = st_ff.int_s1;
        nxt_st.int_s3 = st_ff.int_s2;
        nxt_st.port_s1 = change_sense_port;
        nxt_st.port_s2 = st_ff.port_s1;
        nxt_st.port_s3 = st_ff.port_s2;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    logic int_fall;
    logic port_chg;
    // edges are taken on synchronised copies only; the stages reset to
    // zero, not to the pin level, so no edge counts until all hold samples
    assign int_fall = st_ff.warm[SETTLE_N-1] & st_ff.int_s3 & ~st_ff.int_s2;
    assign port_chg = st_ff.warm[SETTLE_N-1] &
                      (|(st_ff.port_s3 ^ st_ff.port_s2));

    always_comb begin
        evo.ev = '0;
        evo.ev[EV_DIV0] = div0_ovf;
        evo.ev[EV_TMR0] = tmr0_udf;
        evo.ev[EV_PORT] = port_chg;
        evo.ev[EV_TMR1] = tmr1_udf;
        evo.ev[EV_SRC4] = (body_sel == WIEF_BODY_DIV1) ? div1_ovf : int_fall;
    end
endmodule

// *** logic/wief_flags.sv ***
/*
 * Hold wake and interrupt accept enable flag sets, loaded by immediate
 * instructions, with wake request and gated interrupt request outputs.
 * Assumes the decoder gives one-cycle load strobes with the immediate,
 * and that the core latches irq_req bits it accepts.
 */
// Function
// - a wake enable load copies the implemented immediate bits (FLAG_MASK, 8'h97) in one cycle.
// - bit zero set lets a divider 0 overflow end the hold state.
// - bit one set lets a timer 0 underflow end the hold state.
// - bit two set lets any change on the sense port end the hold state.
// - bit four wakes on divider 1 overflow or a falling pin edge by body.
// - bit seven set lets a timer 1 underflow end the hold state.
// - an interrupt enable load copies the implemented immediate bits (FLAG_MASK, 8'h97) in one cycle.
// - interrupt enable bit zero gates the divider 0 interrupt.
// - interrupt enable bit one gates the timer 0 interrupt.
// - interrupt enable bit two gates the port change interrupt.
// - interrupt enable bit four gates the body dependent source 4.
// - interrupt enable bit seven gates the timer 1 interrupt.
module wief_flags
    import wief_pkg::*;
#(
    parameter int PORT_W = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // instruction stream
    input wire logic hold_wake_enable_load,
    input wire logic interrupt_accept_enable_load,
    input wire logic [wief_pkg::FLAG_W-1:0] load_imm,
    // body strap
    input wire wief_pkg::wief_body_t body_sel,
    // event sources
    input wire logic div0_ovf,
    input wire logic tmr0_udf,
    input wire logic div1_ovf,
    input wire logic tmr1_udf,
    input wire logic ext_int_pin,
    input wire logic [PORT_W-1:0] change_sense_port,
    // flag state and requests
    output logic [wief_pkg::FLAG_W-1:0] hold_wake_enable,
    output logic [wief_pkg::FLAG_W-1:0] interrupt_accept_enable,
    output logic hold_release,
    output logic [wief_pkg::FLAG_W-1:0] irq_req
);
    import wief_pkg::*;

    typedef struct packed {
        logic [FLAG_W-1:0] wake;
        logic [FLAG_W-1:0] accept;
        logic rel;
        logic [FLAG_W-1:0] req;
    } wief_st_t;

    wief_st_t st_ff, nxt_st;
    wief_ev_if evb();

    wief_src_sel #(.PORT_W(PORT_W)) u_sel (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .body_sel(body_sel),
        .div0_ovf(div0_ovf),
        .tmr0_udf(tmr0_udf),
        .div1_ovf(div1_ovf),
        .tmr1_udf(tmr1_udf),
        .ext_int_pin(ext_int_pin),
        .change_sense_port(change_sense_port),
        .evo(evb)
    );

    // spread the compact event vector onto flag bit positions
    function automatic logic [FLAG_W-1:0] place_ev(
        input logic [SRC_N-1:0] e
    );
        logic [FLAG_W-1:0] v;
        v = FLAG_ZERO;
        v[BIT_DIV0] = e[EV_DIV0];
        v[BIT_TMR0] = e[EV_TMR0];
        v[BIT_PORT] = e[EV_PORT];
        v[BIT_SRC4] = e[EV_SRC4];
        v[BIT_TMR1] = e[EV_TMR1];
        return v;
    endfunction

    logic [FLAG_W-1:0] ev_pos;
    assign ev_pos = place_ev(evb.ev);

    always_comb begin
        nxt_st = st_ff;
        if (hold_wake_enable_load) begin
            nxt_st.wake = load_imm & FLAG_MASK;
        end
        if (interrupt_accept_enable_load) begin
            nxt_st.accept = load_imm & FLAG_MASK;
        end
        // gating uses the flags in force before this cycle's load
        nxt_st.rel = |(ev_pos & st_ff.wake);
        nxt_st.req = ev_pos & st_ff.accept;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '{wake: FLAG_RESET, accept: FLAG_RESET,
                       rel: 1'b0, req: FLAG_ZERO};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hold_wake_enable = st_ff.wake;
    assign interrupt_accept_enable = st_ff.accept;
    assign hold_release = st_ff.rel;
    assign irq_req = st_ff.req;

    wake_load_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        hold_wake_enable_load |=>
            hold_wake_enable == ($past(load_imm) & FLAG_MASK))
        else $error("wake flags not loaded from immediate");

    accept_load_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        interrupt_accept_enable_load |=>
            interrupt_accept_enable == ($past(load_imm) & FLAG_MASK))
        else $error("accept flags not loaded from immediate");

    wake_hold_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !hold_wake_enable_load |=> $stable(hold_wake_enable))
        else $error("wake flags changed without a load");

    reserved_zero_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        ((hold_wake_enable | interrupt_accept_enable) & ~FLAG_MASK) == 0)
        else $error("reserved flag bit is set");

    div0_wake_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (div0_ovf && hold_wake_enable[BIT_DIV0]) |=> hold_release)
        else $error("divider 0 overflow did not release hold");

    tmr0_irq_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        ##1 irq_req[BIT_TMR0] ==
            ($past(tmr0_udf) && $past(interrupt_accept_enable[BIT_TMR0])))
        else $error("timer 0 request does not match its gate");

    tmr1_wake_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (tmr1_udf && hold_wake_enable[BIT_TMR1]) |=> hold_release)
        else $error("timer 1 underflow did not release hold");

    div0_irq_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (div0_ovf && !interrupt_accept_enable[BIT_DIV0]) |=>
            !irq_req[BIT_DIV0])
        else $error("divider 0 request passed a closed gate");

    src4_irq_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (body_sel == WIEF_BODY_DIV1 && div1_ovf &&
         interrupt_accept_enable[BIT_SRC4]) |=> irq_req[BIT_SRC4])
        else $error("divider 1 request missing on source 4");

    tmr1_irq_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (tmr1_udf && interrupt_accept_enable[BIT_TMR1]) |=>
            irq_req[BIT_TMR1])
        else $error("timer 1 request missing");

    no_wake_a: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (hold_wake_enable == FLAG_ZERO && !hold_wake_enable_load) |=>
            !hold_release)
        else $error("hold released with no wake flag set");
endmodule

// *** verification/wief_flags_tb.sv ***
/*
 * Self-checking bench for the wake and interrupt accept flag block.
 * Assumes the flag block is the top and the bench drives all its ports.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import wief_pkg::*;

    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic hwe_load = 1'b0;
    logic iae_load = 1'b0;
    logic [7:0] load_imm = 8'h00;
    wief_body_t body_sel = WIEF_BODY_DIV1;
    logic div0_ovf = 1'b0;
    logic tmr0_udf = 1'b0;
    logic div1_ovf = 1'b0;
    logic tmr1_udf = 1'b0;
    logic ext_int_pin = 1'b1;
    logic [3:0] change_sense_port = 4'h0;
    logic [7:0] hold_wake_enable;
    logic [7:0] interrupt_accept_enable;
    logic hold_release;
    logic [7:0] irq_req;
    int n_errors = 0;
    int total_checks = 0;
    // index 5 is the source 4 candidate that the body does not select
    int bitpos[6] = '{BIT_DIV0, BIT_TMR0, BIT_PORT, BIT_SRC4, BIT_TMR1, 0};

    wief_flags #(.PORT_W(4)) dut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .hold_wake_enable_load(hwe_load),
        .interrupt_accept_enable_load(iae_load),
        .load_imm(load_imm),
        .body_sel(body_sel),
        .div0_ovf(div0_ovf),
        .tmr0_udf(tmr0_udf),
        .div1_ovf(div1_ovf),
        .tmr1_udf(tmr1_udf),
        .ext_int_pin(ext_int_pin),
        .change_sense_port(change_sense_port),
        .hold_wake_enable(hold_wake_enable),
        .interrupt_accept_enable(interrupt_accept_enable),
        .hold_release(hold_release),
        .irq_req(irq_req)
    );

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one-cycle strobe; flags are compared half a cycle after the taking edge
    task automatic load(logic wake, logic [7:0] imm);
        @(negedge ref_clk);
        hwe_load = wake;
        iae_load = !wake;
        load_imm = imm;
        @(negedge ref_clk);
        hwe_load = 1'b0;
        iae_load = 1'b0;
    endtask

    task automatic fire(int j);
        logic pin_src;
        pin_src = (body_sel == WIEF_BODY_EXTPIN) ? (j == 3) : (j == 5);
        @(negedge ref_clk);
        div0_ovf = (j == 0);
        tmr0_udf = (j == 1);
        if (j == 2) change_sense_port = change_sense_port ^ 4'h5;
        div1_ovf = (j == 3 || j == 5) && !pin_src;
        if (pin_src) ext_int_pin = 1'b0;
        tmr1_udf = (j == 4);
        @(negedge ref_clk);
        {div0_ovf, tmr0_udf, div1_ovf, tmr1_udf} = 4'h0;
    endtask

    task automatic run_reset(wief_body_t b);
        nrst = 1'b0;
        body_sel = b;
        repeat (4) @(negedge ref_clk);
        check8("wake flags in reset", 8'h00, hold_wake_enable);
        check8("accept flags in reset", 8'h00, interrupt_accept_enable);
        check8("requests in reset", 8'h00, {irq_req | {7'h00, hold_release}});
        nrst = 1'b1;
    endtask

    // source k wakes only; every other source is accepted only
    task automatic run_matrix();
        logic [7:0] en;
        int n_rel;
        int n_irq;
        logic [7:0] seen;
        for (int k = 0; k < 5; k++) begin
            en = 8'h01 << bitpos[k];
            load(1'b1, en | 8'h68);
            check8("wake flags", en, hold_wake_enable);
            load(1'b0, ~en);
            check8("accept", 8'h97 & ~en, interrupt_accept_enable);
            check8("wake kept", en, hold_wake_enable);
            for (int j = 0; j < 6; j++) begin
                fire(j);
                n_rel = 0;
                n_irq = 0;
                seen = 8'h00;
                // first look is the edge that drops an internal pulse
                repeat (8) begin
                    n_rel += int'(hold_release === 1'b1);
                    n_irq += int'(irq_req !== 8'h00);
                    seen = seen | irq_req;
                    @(negedge ref_clk);
                end
                ext_int_pin = 1'b1;
                repeat (6) @(negedge ref_clk);
                check8("release count", 8'(j == k), 8'(n_rel));
                check8("release src", 8'(j == k), 8'(n_rel));
                check8("release more", 8'(j == k), 8'(n_rel));
                check8("release also", 8'(j == k), 8'(n_rel));
                check8("release last", 8'(j == k), 8'(n_rel));
                en = (j < 5 && j != k) ? (8'h01 << bitpos[j]) : 8'h00;
                check8("irq bits", en, seen);
                check8("irq cycles", 8'(en != 0), 8'(n_irq));
                check8("irq t1", en & 8'h80, seen & 8'h80);
                en = 8'h01 << bitpos[k];
            end
        end
    endtask

    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        run_reset(WIEF_BODY_DIV1);
        run_matrix();
        run_reset(WIEF_BODY_EXTPIN);
        run_matrix();
        tally_and_finish();
    end
endmodule
